//--- verilog/idle_standby_map.vh
// Register offsets, field positions, reset values and timing counts
// for the IDLE standby controller.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef IDLE_STANDBY_MAP_VH
`define IDLE_STANDBY_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_POWER_SAVE_MODE 4'h0
`define OFS_STANDBY_CONTROL 4'h1
`define OFS_CLOCK_SELECT 4'h2
`define OFS_STANDBY_STATUS 4'h3

// ****************************************
// Field positions
// ****************************************
// Mode register: 0 selects IDLE
`define BIT_POWER_SAVE_SELECT 0
// Control register
`define BIT_STANDBY_TRIGGER 1
`define BIT_MASKABLE_WAKE_MASK 4
`define BIT_PIN_NMI_WAKE_MASK 5
`define BIT_WATCHDOG_NMI_WAKE_MASK 6
// Clock select register
`define BIT_SUBCLOCK_USED 0
`define BIT_CPU_ON_SUBCLOCK 1
`define BIT_WATCH_ON_MAIN 2
`define BIT_T16CH1_FROM_WATCH 3
`define BIT_T8_EXT_BASE 4
`define BIT_T8_MATCH_BASE 6
// Status register
`define BIT_STAT_IDLE 0
`define BIT_STAT_ENTERING 1
`define BIT_STAT_WOKE_NMI 2
`define BIT_STAT_WOKE_MASKABLE 3
`define BIT_STAT_WOKE_ACK 4
`define BIT_STAT_WOKE_RESET 5

// ****************************************
// Reset values
// ****************************************
`define RST_POWER_SAVE_MODE 8'h00
`define RST_STANDBY_CONTROL 8'h00
`define RST_CLOCK_SELECT 8'h00

// ****************************************
// Timing
// ****************************************
// Clock period in ns and the settle time before the gates close
`define CLK_PERIOD_NS 10
`define ENTRY_SETTLE_NS 20
`define ENTRY_SETTLE_CYCLES ((`ENTRY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- verilog/idle_standby_control.v
// IDLE standby controller: entry by register write, clock gating of the
// CPU and gated peripherals, wake decision and post-wake direction.
// Assumes one 100 MHz main clock, synchronous inputs, a simple register
// port and an interrupt controller that reports priorities.
//
// Behaviour
// R1 - Select bit 0 plus trigger enters IDLE
// R2 - IDLE gates CPU and peripheral clocks off
// R3 - RAM held; subclock peripherals keep clocking
// R4 - Wake returns to normal with no wait
// R5 - Software puts five NOPs after trigger write
// R6 - Wake on NMI, watchdog, IRQs, resets
// R7 - Any unmasked request wakes regardless of priority
// R8 - Lower priority in handler: wake, stay pending
// R9 - Higher priority or NMI: wake and acknowledge
// R10 - NMI wake branches to its handler
// R11 - Maskable wake: disabled resumes, enabled may branch
// R12 - Wake mask bits set block the wake
// R13 - Reset wake performs ordinary reset sequence
// R14 - Interrupt controller and most timers stop
// R15 - Timer16 ch1 runs only from watch interrupt
// R16 - Timer8 runs from external or ch1 match
// R17 - Clock gates switch synchronously, glitch free

`timescale 1ns/100ps
`default_nettype none
`include "idle_standby_map.vh"

module idle_standby_control (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // Wake sources
    input wire nmi_pin,
    input wire watchdog_b_interrupt,
    input wire watchdog_b_reset,
    input wire [7:0] external_irq_pins,
    input wire [7:0] external_irq_enable,
    input wire peripheral_irq,
    // Interrupt controller state
    input wire irq_globally_enabled,
    input wire in_service,
    input wire [2:0] request_priority,
    input wire [2:0] service_priority,
    // Clock enables
    output reg main_osc_enable,
    output reg cpu_clk_enable,
    output reg gated_periph_clk_enable,
    output reg subclock_periph_clk_enable,
    output reg watch_main_clk_enable,
    output reg timer16_ch1_clk_enable,
    output reg [1:0] timer8_clk_enable,
    output reg ram_hold,
    // Wake results
    output reg wake_nmi_branch,
    output reg wake_irq_ack,
    output reg wake_resume_next,
    output reg wake_reset_request
);

    // ****************************************
    // States
    // ****************************************
    localparam [1:0] st_normal = 2'b00;
    localparam [1:0] st_entering = 2'b01;
    localparam [1:0] st_idle = 2'b10;
    // Count held as an integer first so the cut to three bits is deliberate
    localparam integer settle_total = `ENTRY_SETTLE_CYCLES;
    localparam [2:0] settle_count = settle_total[2:0];
    localparam [7:0] mode_reset = `RST_POWER_SAVE_MODE; // Mode register after reset

    // ****************************************
    // Functions
    // ****************************************

    // Timer8 keeps counting in IDLE from its own pin or the ch1 match
    function timer8_may_run;
        input ext_sel;
        input match_sel;
        input ch1_running;
        begin
            timer8_may_run = ext_sel | (match_sel & ch1_running);
        end
    endfunction

    // ****************************************
    // Registers and state
    // ****************************************
    reg [1:0] state; // Controller state
    reg [1:0] next_state; // State for next cycle
    reg [2:0] settle; // Cycles left before gates close
    reg power_save_select_bit; // Mode select, 0 picks IDLE
    reg maskable_wake_mask; // Blocks maskable wake when set
    reg pin_nmi_wake_mask; // Blocks pin NMI wake when set
    reg watchdog_nmi_wake_mask; // Blocks watchdog NMI wake when set
    reg [7:0] clock_select; // Clock source selections
    reg woke_nmi; // Last wake was by NMI
    reg woke_maskable; // Last wake was maskable
    reg woke_ack; // Last wake was acknowledged
    reg woke_reset; // Last IDLE ended by watchdog reset
    wire in_idle; // Gates closed now
    wire nmi_wake; // Unmasked non-maskable request
    wire maskable_wake; // Unmasked maskable request
    wire higher_priority; // Request beats the one in service
    wire wdt_reset_wake; // Watchdog reset that ends IDLE
    wire trigger_write; // Valid IDLE entry write
    wire ch1_run; // Timer16 ch1 allowed in IDLE
    wire watch_running; // Watch timer has a clock in IDLE
    wire [1:0] t8_run; // Timer8 allowed in IDLE
    wire [7:0] status_word; // Status read value

    assign in_idle = (state == st_idle);

    // ****************************************
    // Wake decode
    // ****************************************

    // R12 mask bits
    // R6 NMI sources
    assign nmi_wake = (nmi_pin & ~pin_nmi_wake_mask)
        | (watchdog_b_interrupt & clock_select[`BIT_CPU_ON_SUBCLOCK] & ~watchdog_nmi_wake_mask);

    // R7 any unmasked request
    // R12 maskable gate
    assign maskable_wake = ~maskable_wake_mask
        & ((|(external_irq_pins & external_irq_enable)) | peripheral_irq);

    // Lower code is the more urgent priority
    assign higher_priority = ~in_service | (request_priority < service_priority);

    // R6 watchdog reset wake
    // Only counts when the CPU runs on the subclock; otherwise it is stopped.
    assign wdt_reset_wake = watchdog_b_reset & clock_select[`BIT_CPU_ON_SUBCLOCK];

    // R1 entry condition
    // The select bit is taken as it stood before this write.
    assign trigger_write = reg_write & (reg_addr == `OFS_STANDBY_CONTROL)
        & reg_wdata[`BIT_STANDBY_TRIGGER] & ~power_save_select_bit & (state == st_normal);

    // ****************************************
    // Peripheral run decode
    // ****************************************

    // R15 watch clock
    assign watch_running = clock_select[`BIT_SUBCLOCK_USED] | clock_select[`BIT_WATCH_ON_MAIN];
    // R15 ch1 source
    assign ch1_run = clock_select[`BIT_T16CH1_FROM_WATCH] & watch_running;

    // R16 timer8 sources
    genvar m;
    generate
        for (m = 0; m < 2; m = m + 1) begin : g_t8
            assign t8_run[m] = timer8_may_run(clock_select[`BIT_T8_EXT_BASE + m],
                clock_select[`BIT_T8_MATCH_BASE + m], ch1_run);
        end
    endgenerate

    // ****************************************
    // Next state
    // ****************************************

    // Entry waits a short settle time; exit is at once
    always @* begin
        next_state = state;
        case (state)
            st_normal: begin
                if (trigger_write) begin
                    next_state = st_entering;
                end
            end
            st_entering: begin
                // Wake before the gates close simply cancels entry
                if (nmi_wake | maskable_wake) begin
                    next_state = st_normal;
                end else if (settle == 3'h0) begin
                    next_state = st_idle;
                end
            end
            st_idle: begin
                // R4 immediate return
                if (nmi_wake | maskable_wake) begin
                    next_state = st_normal;
                end
            end
            default: begin
                next_state = st_normal;
            end
        endcase
    end

    // ****************************************
    // State and registers
    // ****************************************

    // R13 reset wake
    // A watchdog reset takes the same path as the pin reset.
    always @(posedge clk) begin
        if (!reset_n || wdt_reset_wake) begin
            state <= st_normal;
            settle <= 3'h0;
            power_save_select_bit <= mode_reset[`BIT_POWER_SAVE_SELECT];
            maskable_wake_mask <= 1'b0;
            pin_nmi_wake_mask <= 1'b0;
            watchdog_nmi_wake_mask <= 1'b0;
            clock_select <= `RST_CLOCK_SELECT;
            woke_nmi <= 1'b0;
            woke_maskable <= 1'b0;
            woke_ack <= 1'b0;
        end else begin
            state <= next_state;
            // Settle counter loads on entry and counts down
            if (trigger_write) begin
                settle <= settle_count - 3'h1;
            end else if (settle != 3'h0) begin
                settle <= settle - 3'h1;
            end
            // Register writes are only possible while the CPU runs
            if (reg_write && reg_addr == `OFS_POWER_SAVE_MODE) begin
                power_save_select_bit <= reg_wdata[`BIT_POWER_SAVE_SELECT];
            end
            if (reg_write && reg_addr == `OFS_STANDBY_CONTROL) begin
                maskable_wake_mask <= reg_wdata[`BIT_MASKABLE_WAKE_MASK];
                pin_nmi_wake_mask <= reg_wdata[`BIT_PIN_NMI_WAKE_MASK];
                watchdog_nmi_wake_mask <= reg_wdata[`BIT_WATCHDOG_NMI_WAKE_MASK];
            end
            if (reg_write && reg_addr == `OFS_CLOCK_SELECT) begin
                clock_select <= reg_wdata;
            end
            // Wake cause is recorded on leaving IDLE
            if (in_idle && next_state == st_normal) begin
                woke_nmi <= nmi_wake;
                woke_maskable <= ~nmi_wake;
                woke_ack <= nmi_wake | (higher_priority & irq_globally_enabled);
            end
        end
    end

    // Reset cause survives its own reset so software can see it
    always @(posedge clk) begin
        if (!reset_n) begin
            woke_reset <= 1'b0;
        end else if (wdt_reset_wake) begin
            woke_reset <= in_idle;
        end else if (trigger_write) begin
            woke_reset <= 1'b0;
        end
    end

    // ****************************************
    // Clock gates
    // ****************************************

    // R17 registered gates
    // Enables change only on the clock edge, so the cell gates see clean levels.
    always @(posedge clk) begin
        if (!reset_n || wdt_reset_wake) begin
            main_osc_enable <= 1'b1;
            cpu_clk_enable <= 1'b1;
            gated_periph_clk_enable <= 1'b1;
            subclock_periph_clk_enable <= 1'b1;
            watch_main_clk_enable <= 1'b1;
            timer16_ch1_clk_enable <= 1'b1;
            timer8_clk_enable <= 2'b11;
            ram_hold <= 1'b0;
        end else begin
            // R2 oscillator stays on
            main_osc_enable <= 1'b1;
            // R2 CPU gated
            cpu_clk_enable <= (next_state != st_idle);
            // R14 stopped blocks
            gated_periph_clk_enable <= (next_state != st_idle);
            // R3 subclock peripherals
            subclock_periph_clk_enable <= 1'b1;
            // R15 main clock to watch timer
            watch_main_clk_enable <= (next_state != st_idle)
                | (~clock_select[`BIT_SUBCLOCK_USED] & clock_select[`BIT_WATCH_ON_MAIN]);
            // R15 ch1 enable
            timer16_ch1_clk_enable <= (next_state != st_idle) | ch1_run;
            // R16 timer8 enables
            timer8_clk_enable <= {2{next_state != st_idle}} | t8_run;
            // R3 RAM write block
            ram_hold <= (next_state == st_idle);
        end
    end

    // ****************************************
    // Wake direction pulses
    // ****************************************

    // One-cycle pulses to the CPU sequencer on the wake edge
    always @(posedge clk) begin
        if (!reset_n) begin
            wake_nmi_branch <= 1'b0;
            wake_irq_ack <= 1'b0;
            wake_resume_next <= 1'b0;
            wake_reset_request <= 1'b0;
        end else begin
            wake_reset_request <= wdt_reset_wake & in_idle;
            if (in_idle && next_state == st_normal && !wdt_reset_wake) begin
                // R10 NMI branch
                wake_nmi_branch <= nmi_wake;
                // R9 acknowledge higher
                // R11 enabled may branch
                wake_irq_ack <= ~nmi_wake & higher_priority & irq_globally_enabled;
                // R8 lower stays pending
                // R11 disabled resumes
                wake_resume_next <= ~nmi_wake & ~(higher_priority & irq_globally_enabled);
            end else begin
                wake_nmi_branch <= 1'b0;
                wake_irq_ack <= 1'b0;
                wake_resume_next <= 1'b0;
            end
        end
    end

    // ****************************************
    // Register read
    // ****************************************

    assign status_word = {2'b00, woke_reset, woke_ack, woke_maskable, woke_nmi,
        (state == st_entering), in_idle};

    // Read data stands one cycle after the strobe; unmapped reads give zero
    always @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `OFS_POWER_SAVE_MODE: begin
                    reg_rdata <= {7'h00, power_save_select_bit};
                end
                `OFS_STANDBY_CONTROL: begin
                    // Trigger bit always reads back 0
                    reg_rdata <= {1'b0, watchdog_nmi_wake_mask, pin_nmi_wake_mask,
                        maskable_wake_mask, 4'h0};
                end
                `OFS_CLOCK_SELECT: begin
                    reg_rdata <= clock_select;
                end
                `OFS_STANDBY_STATUS: begin
                    reg_rdata <= status_word;
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

`default_nettype wire

//--- bench/idle_standby_checker_sva.sv
// Checker for the IDLE standby controller, bound to its ports.
// Assumes one main clock and the register offsets of the design.
`timescale 1ns/100ps
`default_nettype none
module idle_standby_checker (
    // Clock, reset and register writes
    input wire logic clk, reset_n, reg_write,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata, external_irq_pins, external_irq_enable,
    // Wake sources and interrupt controller state
    input wire logic nmi_pin, watchdog_b_interrupt, watchdog_b_reset, peripheral_irq,
    input wire logic irq_globally_enabled, in_service,
    input wire logic [2:0] request_priority, service_priority,
    // Clock enables and wake pulses
    input wire logic main_osc_enable, cpu_clk_enable, gated_periph_clk_enable,
    input wire logic subclock_periph_clk_enable, watch_main_clk_enable, timer16_ch1_clk_enable,
    input wire logic [1:0] timer8_clk_enable,
    input wire logic ram_hold, wake_nmi_branch, wake_irq_ack, wake_resume_next, wake_reset_request
);
    // Shadow of select bit, wake masks and clock select
    logic sel;
    logic [2:0] msk;
    logic [7:0] cs;
    // Watchdog reset only counts with the CPU on the subclock
    wire logic wdr = watchdog_b_reset && cs[1];
    wire logic mreq = peripheral_irq || |(external_irq_pins & external_irq_enable);
    wire logic nq = !nmi_pin && !watchdog_b_interrupt && !wdr;
    // True while no unmasked source asks for a wake
    wire logic stay = !wdr && (!nmi_pin || msk[1]) && (!watchdog_b_interrupt || msk[2] || !cs[1])
        && (!mreq || msk[0]);

    // ****************************************
    // Shadow registers
    // ****************************************
    // Follow writes; a watchdog reset clears them like the design
    always @(posedge clk) begin
        if (!reset_n || wdr) begin
            sel <= 1'h0;
            msk <= 3'h0;
            cs <= 8'h00;
        end else if (reg_write && reg_addr == 4'h0) begin
            sel <= reg_wdata[0];
        end else if (reg_write && reg_addr == 4'h1) begin
            msk <= reg_wdata[6:4];
        end else if (reg_write && reg_addr == 4'h2) begin
            cs <= reg_wdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_ENTRY: assert property (reg_write && reg_addr == 4'h1 && reg_wdata[1] && !sel && cpu_clk_enable
        && !ram_hold ##1 stay [*2] |=> ram_hold && !cpu_clk_enable) else $error("idle not reached");
    AST_GATES: assert property (ram_hold |-> !cpu_clk_enable && !gated_periph_clk_enable)
        else $error("gated clocks running in idle");
    AST_OSC: assert property (main_osc_enable && subclock_periph_clk_enable)
        else $error("oscillator or subclock enable dropped");
    AST_NMI: assert property (ram_hold && nmi_pin && !msk[1] && !wdr |=> wake_nmi_branch && cpu_clk_enable)
        else $error("nmi wake missing");
    AST_ACK: assert property (ram_hold && nq && mreq && !msk[0] && irq_globally_enabled
        && (!in_service || request_priority < service_priority) |=> wake_irq_ack) else $error("ack missing");
    AST_LOW: assert property (ram_hold && nq && mreq && !msk[0] && in_service
        && request_priority > service_priority |=> wake_resume_next && !wake_irq_ack) else $error("low wake wrong");
    AST_MASKED: assert property (ram_hold && stay |=> ram_hold) else $error("masked source woke");
    AST_WDRST: assert property (ram_hold && wdr |-> ##[1:2] wake_reset_request)
        else $error("watchdog reset wake missing");
    AST_ONEPULSE: assert property ($onehot0({wake_nmi_branch, wake_irq_ack, wake_resume_next,
        wake_reset_request})) else $error("several wake pulses");
    AST_T16: assert property (ram_hold |-> timer16_ch1_clk_enable == (cs[3] && (cs[0] || cs[2]))
        && watch_main_clk_enable == (!cs[0] && cs[2])) else $error("timer16 or watch enable wrong");
    AST_T8: assert property (ram_hold |-> timer8_clk_enable
        == (cs[5:4] | (cs[7:6] & {2{timer16_ch1_clk_enable}}))) else $error("timer8 enable wrong");
    COV_NMI: cover property (wake_nmi_branch);
    COV_ACK: cover property (wake_irq_ack);
    COV_RESUME: cover property (wake_resume_next);
endmodule

bind idle_standby_control idle_standby_checker i_chk (.*);
`default_nettype wire

//--- bench/wake_source_model.sv
// Far-side model: interrupt sources and watchdog that wake the block.
// Assumes one-cycle raise commands from the bench on the main clock.
`timescale 1ns/100ps
`default_nettype none
module wake_source_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Command: bit0 NMI, 1 watchdog NMI, 2 pin 0, 3 peripheral, 4 watchdog reset
    input wire logic raise,
    input wire logic [4:0] req,
    // Answers from the block
    input wire logic wake_nmi_branch,
    input wire logic wake_irq_ack,
    input wire logic wake_reset_request,
    // Request levels
    output logic nmi_pin,
    output logic watchdog_b_interrupt,
    output logic [7:0] external_irq_pins,
    output logic peripheral_irq,
    output logic watchdog_b_reset
);
    // Held request levels
    logic [4:0] lvl;

    // ****************************************
    // Request hold
    // ****************************************
    // levels held until taken
    always @(posedge clk) begin
        if (!reset_n) begin
            lvl <= 5'h00;
        end else if (raise) begin
            lvl <= req;
        end else if (wake_nmi_branch || wake_irq_ack || wake_reset_request) begin
            // A resumed but unacknowledged request stays pending
            lvl <= 5'h00;
        end
    end
    assign nmi_pin = lvl[0];
    assign watchdog_b_interrupt = lvl[1];
    assign external_irq_pins = {7'h00, lvl[2]};
    assign peripheral_irq = lvl[3];
    assign watchdog_b_reset = lvl[4];
endmodule
`default_nettype wire

//--- bench/idle_standby_control_test.sv
// Self-checking bench for the IDLE standby controller.
// Assumes the wake source model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module idle_standby_control_test;
    // Wake case: setup, request kind, expected pulses {nmi, ack, resume, reset}
    typedef struct packed {
        logic [7:0] ctrl, csel;
        logic [4:0] kind;
        logic gie, svc;
        logic [2:0] prio;
        logic [3:0] exp;
        logic idle;
    } row_t;
    localparam row_t rows [0:11] = '{
        '{8'h00, 8'h00, 5'h01, 1'h1, 1'h0, 3'h1, 4'h8, 1'h0},
        '{8'h20, 8'h00, 5'h01, 1'h1, 1'h0, 3'h1, 4'h0, 1'h1},
        '{8'h00, 8'h02, 5'h02, 1'h1, 1'h0, 3'h1, 4'h8, 1'h0},
        '{8'h40, 8'h02, 5'h02, 1'h1, 1'h0, 3'h1, 4'h0, 1'h1},
        '{8'h00, 8'h00, 5'h02, 1'h1, 1'h0, 3'h1, 4'h0, 1'h1},
        '{8'h00, 8'h00, 5'h04, 1'h1, 1'h0, 3'h5, 4'h4, 1'h0},
        '{8'h00, 8'h00, 5'h04, 1'h1, 1'h1, 3'h5, 4'h2, 1'h0},
        '{8'h00, 8'h00, 5'h04, 1'h1, 1'h1, 3'h1, 4'h4, 1'h0},
        '{8'h00, 8'h00, 5'h08, 1'h0, 1'h0, 3'h1, 4'h2, 1'h0},
        '{8'h10, 8'h00, 5'h08, 1'h1, 1'h0, 3'h1, 4'h0, 1'h1},
        '{8'h00, 8'h02, 5'h10, 1'h1, 1'h0, 3'h1, 4'h1, 1'h0},
        '{8'h00, 8'h00, 5'h10, 1'h1, 1'h0, 3'h1, 4'h0, 1'h1}};
    // Design and model ports
    logic clk = 1'h0, reset_n = 1'h0, reg_write = 1'h0, reg_read = 1'h0, raise = 1'h0;
    logic irq_globally_enabled = 1'h0, in_service = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, external_irq_pins;
    logic [7:0] external_irq_enable = 8'h01;
    logic [4:0] req = 5'h00;
    logic [2:0] request_priority = 3'h0, service_priority = 3'h3;
    logic nmi_pin, watchdog_b_interrupt, watchdog_b_reset, peripheral_irq, main_osc_enable;
    logic cpu_clk_enable, gated_periph_clk_enable, subclock_periph_clk_enable, watch_main_clk_enable;
    logic timer16_ch1_clk_enable, ram_hold, wake_nmi_branch, wake_irq_ack, wake_resume_next;
    logic wake_reset_request;
    logic [1:0] timer8_clk_enable;
    // Wake pulses gathered since the last reset
    logic [3:0] seen;
    int fails = 0, samples_checked = 0, cycles = 0;

    idle_standby_control i_dut (.*);
    wake_source_model i_src (.*);

    initial forever #5 clk = ~clk;

    // Sticky record so a one-cycle pulse is never missed
    always @(posedge clk) begin
        seen <= reset_n ? (seen | {wake_nmi_branch, wake_irq_ack, wake_resume_next, wake_reset_request}) : 4'h0;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        samples_checked++;
        if (got !== want) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'h0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_read <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'h0;
        #1;
        check(reg_rdata, e);
    endtask
    task automatic do_reset();
        @(posedge clk);
        reset_n <= 1'h0;
        repeat (3) @(posedge clk);
        reset_n <= 1'h1;
    endtask
    task automatic enter(input logic [7:0] cs, input logic [7:0] ctrl);
        wr(4'h2, cs);
        wr(4'h0, 8'h00);
        wr(4'h1, ctrl | 8'h02);
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        // Table of wake cases, a fresh reset for each
        for (int i = 0; i < 12; i++) begin
            do_reset();
            irq_globally_enabled <= rows[i].gie;
            in_service <= rows[i].svc;
            request_priority <= rows[i].prio;
            enter(rows[i].csel, rows[i].ctrl);
            check({6'h00, cpu_clk_enable, gated_periph_clk_enable}, 8'h00);
            check({5'h00, ram_hold, main_osc_enable, subclock_periph_clk_enable}, 8'h07);
            @(posedge clk);
            raise <= 1'h1;
            req <= rows[i].kind;
            @(posedge clk);
            raise <= 1'h0;
            repeat (4) @(posedge clk);
            #1;
            check({4'h0, seen}, {4'h0, rows[i].exp});
            check({6'h00, ram_hold, cpu_clk_enable}, {6'h00, rows[i].idle, !rows[i].idle});
            // Status shows the wake cause
            rd_chk(4'h3, {2'h0, rows[i].exp[0], rows[i].exp[3] | rows[i].exp[2], rows[i].exp[2] | rows[i].exp[1],
                rows[i].exp[3], 1'h0, rows[i].idle});
        end
        // Reset values after a mid-run reset, one unmapped offset
        do_reset();
        for (int a = 0; a < 5; a++) begin
            rd_chk(a[3:0], 8'h00);
        end
        // Trigger refused while select bit is 1
        do_reset();
        wr(4'h0, 8'h01);
        rd_chk(4'h0, 8'h01);
        wr(4'h1, 8'h02);
        repeat (4) @(posedge clk);
        #1;
        check({7'h00, cpu_clk_enable}, 8'h01);
        // Request during entry cancels it with no pulse
        do_reset();
        wr(4'h0, 8'h00);
        @(posedge clk);
        reg_write <= 1'h1;
        reg_addr <= 4'h1;
        reg_wdata <= 8'h02;
        raise <= 1'h1;
        req <= 5'h01;
        @(posedge clk);
        reg_write <= 1'h0;
        raise <= 1'h0;
        repeat (4) @(posedge clk);
        #1;
        check({4'h0, seen}, 8'h00);
        check({6'h00, ram_hold, cpu_clk_enable}, 8'h01);
        // Timer clocks kept in idle, status shows idle
        do_reset();
        enter(8'h9c, 8'h00);
        check({4'h0, watch_main_clk_enable, timer16_ch1_clk_enable, timer8_clk_enable}, 8'h0f);
        rd_chk(4'h3, 8'h01);
        tally_and_finish();
    end
endmodule
`default_nettype wire
